// >>> logic/tcp_pkg.sv
/*
 Constants, register map and carrier types for the 8-bit timer/counter
 with two compare channels and waveform generation.
 Assumes a single 200 MHz clock and a plain register port.
*/
// What this block does
// - Counter advances only on the selected tick; clock select zero stops it.
// - Software can read and write the count at any time.
// - A software write to the count beats a same-cycle clear or count.
// - Count sequence and overflow flag follow the three-bit waveform mode.
// - Count equal to a compare value sets that channel's flag at next tick.
// - Flags request interrupts when enabled; clear on service or on writing one.
// - In fast PWM the overflow flag sets each time the count reaches TOP.
// - Fast PWM channel A: 00 off, 10 clear/set, 11 set/clear, 01 toggles if bit2.
// - Only channel A offers toggle in fast PWM; channel B does not.
// - Waveform reaches the pin only while its direction bit selects output.
// - Fast PWM output changes at match and goes opposite at TOP-to-BOTTOM wrap.
// - Fast PWM period is 256 ticks in mode 3; prescale 1, 8, 64, 256 or 1024.
// - Compare A at BOTTOM gives one-tick spike every MAX+1 ticks.
// - Compare A at MAX gives a constant output level.
// - Toggle mode gives 50% duty, up to half the clock with compare zero.
// - Any nonzero channel A mode bit hands the pin to the waveform output, except 01 in fast PWM with bit2 clear.
// - Non-PWM channel A: 00 off, 01 toggle, 10 clear, 11 set on match.
// - Fast PWM, compare A equals TOP with mode bit1 set: match ignored.
// - Control A: A mode 7:6, B mode 5:4, wave bits 1:0, 3:2 read zero.
package tcp_pkg;

    // Register offsets
    localparam logic [3:0] ADDR_CONTROL_A = 4'h0;
    localparam logic [3:0] ADDR_CONTROL_B = 4'h1;
    localparam logic [3:0] ADDR_COUNT     = 4'h2;
    localparam logic [3:0] ADDR_COMPARE_A = 4'h3;
    localparam logic [3:0] ADDR_COMPARE_B = 4'h4;
    localparam logic [3:0] ADDR_FLAGS     = 4'h5;
    localparam logic [3:0] ADDR_INT_EN    = 4'h6;
    localparam logic [3:0] ADDR_SERVICE   = 4'h7;
    localparam logic [3:0] ADDR_DIRECTION = 4'h8;

    // Field positions in flags, enable and service registers
    localparam int BIT_OVF   = 0;
    localparam int BIT_CMP_A = 1;
    localparam int BIT_CMP_B = 2;
    // Direction register bits
    localparam int BIT_DIR_A = 0;
    localparam int BIT_DIR_B = 1;
    // Waveform mode bit 2 sits in control B bit 3
    localparam int BIT_WGM2  = 3;

    localparam logic [7:0] RESET_BYTE   = 8'h00;
    localparam logic [7:0] CONTROL_A_RD = 8'hF3; // 3:2 read zero
    localparam logic [7:0] COUNT_MAX    = 8'hFF;
    localparam logic [7:0] COUNT_BOTTOM = 8'h00;

    // Prescale taps
    localparam int PRESCALE_W = 10;
    localparam logic [9:0] DIV_8    = 10'h007;
    localparam logic [9:0] DIV_64   = 10'h03F;
    localparam logic [9:0] DIV_256  = 10'h0FF;
    localparam logic [9:0] DIV_1024 = 10'h3FF;

    typedef enum logic [2:0] {
        CS_STOP, CS_DIV1, CS_DIV8, CS_DIV64, CS_DIV256, CS_DIV1024, CS_RSV6, CS_RSV7
    } tcp_clk_sel_t;

    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } tcp_bus_req_t;

    typedef struct packed {
        logic [1:0] mode_a;
        logic [1:0] mode_b;
        logic [2:0] wave;
    } tcp_config_t;

endpackage

// >>> logic/tcp_timer.sv
/*
 8-bit timer/counter with prescaler, two compare channels, overflow
 and compare flags, and the waveform generator driving two pins.
 Assumes bus strobes come from logic on clk_i; the service inputs are
 one-cycle pulses from the interrupt controller on the same clock.
*/
`timescale 1ns/1ps
module tcp_timer (
    input  wire logic               clk_i,
    input  wire logic               reset_i,
    input  wire tcp_pkg::tcp_bus_req_t bus_i,
    output logic [7:0]              rdata_o,
    input  wire logic               service_a_i,
    input  wire logic               service_b_i,
    input  wire logic               service_ovf_i,
    output logic [2:0]              irq_o,
    output logic                    wave_out_a_o,
    output logic                    wave_out_a_oe_o,
    output logic                    wave_out_b_o,
    output logic                    wave_out_b_oe_o
);

    tcp_pkg::tcp_config_t cfg;
    logic [2:0]  clock_select;
    logic [7:0]  timer_count;
    logic [7:0]  compare_value_a;
    logic [7:0]  compare_value_b;
    logic [2:0]  flags;
    logic [2:0]  int_en;
    logic [1:0]  direction;
    logic [9:0]  prescale;
    logic        timer_tick;
    logic        wave_a;
    logic        wave_b;
    logic        match_a_q;
    logic        match_b_q;
    logic        count_wr;
    logic [7:0]  top_value;
    logic        at_top;
    logic        fast_pwm;
    logic [7:0]  next_count;

    assign count_wr = bus_i.wr && bus_i.addr == tcp_pkg::ADDR_COUNT;

    // Control registers; reserved bits are simply not stored
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            cfg          <= '0;
            clock_select <= 3'h0;
            compare_value_a <= tcp_pkg::RESET_BYTE;
            compare_value_b <= tcp_pkg::RESET_BYTE;
            int_en       <= 3'h0;
            direction    <= 2'h0;
        end else if (bus_i.wr) begin
            case (bus_i.addr)
                tcp_pkg::ADDR_CONTROL_A: begin
                    cfg.mode_a    <= bus_i.wdata[7:6];
                    cfg.mode_b    <= bus_i.wdata[5:4];
                    cfg.wave[1:0] <= bus_i.wdata[1:0];
                end
                tcp_pkg::ADDR_CONTROL_B: begin
                    cfg.wave[2]  <= bus_i.wdata[tcp_pkg::BIT_WGM2];
                    clock_select <= bus_i.wdata[2:0];
                end
                tcp_pkg::ADDR_COMPARE_A: compare_value_a <= bus_i.wdata;
                tcp_pkg::ADDR_COMPARE_B: compare_value_b <= bus_i.wdata;
                tcp_pkg::ADDR_INT_EN:    int_en <= bus_i.wdata[2:0];
                tcp_pkg::ADDR_DIRECTION: direction <= bus_i.wdata[1:0];
                default: ;
            endcase
        end
    end

    // Free-running prescaler; taps chosen so the division is exact
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            prescale <= 10'h000;
        end else begin
            prescale <= prescale + 10'h001;
        end
    end

    // Tick selection; reserved codes behave as stopped
    always_comb begin
        case (tcp_pkg::tcp_clk_sel_t'(clock_select))
            tcp_pkg::CS_STOP:    timer_tick = 1'b0;
            tcp_pkg::CS_DIV1:    timer_tick = 1'b1;
            tcp_pkg::CS_DIV8:    timer_tick = (prescale[2:0] == tcp_pkg::DIV_8[2:0]);
            tcp_pkg::CS_DIV64:   timer_tick = (prescale[5:0] == tcp_pkg::DIV_64[5:0]);
            tcp_pkg::CS_DIV256:  timer_tick = (prescale[7:0] == tcp_pkg::DIV_256[7:0]);
            tcp_pkg::CS_DIV1024: timer_tick = (prescale == tcp_pkg::DIV_1024);
            default:             timer_tick = 1'b0;
        endcase
    end

    // Mode decode: 3 and 7 are fast PWM, 2 is clear-on-match, 7 tops at compare A
    assign fast_pwm  = (cfg.wave[1:0] == 2'h3);
    assign top_value = (cfg.wave == 3'h7 || cfg.wave == 3'h2) ? compare_value_a
                                                               : tcp_pkg::COUNT_MAX;
    assign at_top    = (timer_count == top_value);

    // Count sequence: wrap to bottom at TOP, else increment
    always_comb begin
        next_count = timer_count;
        if (timer_tick) begin
            next_count = at_top ? tcp_pkg::COUNT_BOTTOM : timer_count + 8'h01;
        end
    end

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            timer_count <= tcp_pkg::RESET_BYTE;
        end else if (count_wr) begin
            timer_count <= bus_i.wdata;
        end else begin
            timer_count <= next_count;
        end
    end

    // Compare latched; flag sets at the following tick
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            match_a_q <= 1'b0;
            match_b_q <= 1'b0;
        end else if (timer_tick) begin
            match_a_q <= (timer_count == compare_value_a);
            match_b_q <= (timer_count == compare_value_b);
        end
    end

    // Flags: set beats clear by one-write or by service
    logic [2:0] flag_set;
    logic [2:0] flag_clr;
    assign flag_set[tcp_pkg::BIT_OVF]   = timer_tick && at_top;
    assign flag_set[tcp_pkg::BIT_CMP_A] = timer_tick && match_a_q;
    assign flag_set[tcp_pkg::BIT_CMP_B] = timer_tick && match_b_q;
    assign flag_clr = ((bus_i.wr && bus_i.addr == tcp_pkg::ADDR_FLAGS) ? bus_i.wdata[2:0]
                                                                      : 3'h0)
                    | {service_b_i, service_a_i, service_ovf_i};

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            flags <= 3'h0;
        end else begin
            flags <= flag_set | (flags & ~flag_clr);
        end
    end

    assign irq_o = flags & int_en;

    // Channel A waveform
    logic hit_a;
    logic hit_b;
    logic wrap;
    assign wrap  = timer_tick && at_top;
    assign hit_a = timer_tick && timer_count == compare_value_a;
    assign hit_b = timer_tick && timer_count == compare_value_b;

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            wave_a <= 1'b0;
        end else if (fast_pwm) begin
            case (cfg.mode_a)
                2'h1: if (cfg.wave[2] && hit_a) wave_a <= ~wave_a;
                2'h2: begin
                    // Wrap wins so compare at TOP is ignored
                    if (wrap) wave_a <= 1'b1;
                    else if (hit_a) wave_a <= 1'b0;
                end
                2'h3: begin
                    if (wrap) wave_a <= 1'b0;
                    else if (hit_a) wave_a <= 1'b1;
                end
                default: ;
            endcase
        end else if (hit_a) begin
            case (cfg.mode_a)
                2'h1: wave_a <= ~wave_a;
                2'h2: wave_a <= 1'b0;
                2'h3: wave_a <= 1'b1;
                default: ;
            endcase
        end
    end

    // Channel B waveform: no toggle in fast PWM
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            wave_b <= 1'b0;
        end else if (fast_pwm) begin
            case (cfg.mode_b)
                2'h2: begin
                    if (wrap) wave_b <= 1'b1;
                    else if (hit_b) wave_b <= 1'b0;
                end
                2'h3: begin
                    if (wrap) wave_b <= 1'b0;
                    else if (hit_b) wave_b <= 1'b1;
                end
                default: ;
            endcase
        end else if (hit_b) begin
            case (cfg.mode_b)
                2'h1: wave_b <= ~wave_b;
                2'h2: wave_b <= 1'b0;
                2'h3: wave_b <= 1'b1;
                default: ;
            endcase
        end
    end

    // Pin drive: connected only with nonzero mode and direction set
    logic conn_a;
    logic conn_b;
    assign conn_a = (cfg.mode_a != 2'h0)
                 && !(fast_pwm && cfg.mode_a == 2'h1 && !cfg.wave[2]);
    assign conn_b = (cfg.mode_b != 2'h0) && !(fast_pwm && cfg.mode_b == 2'h1);
    assign wave_out_a_o    = wave_a;
    assign wave_out_b_o    = wave_b;
    assign wave_out_a_oe_o = conn_a && direction[tcp_pkg::BIT_DIR_A];
    assign wave_out_b_oe_o = conn_b && direction[tcp_pkg::BIT_DIR_B];

    // Read data one cycle after the strobe
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            rdata_o <= 8'h00;
        end else if (bus_i.rd) begin
            case (bus_i.addr)
                tcp_pkg::ADDR_CONTROL_A: rdata_o <= {cfg.mode_a, cfg.mode_b, 2'h0, cfg.wave[1:0]};
                tcp_pkg::ADDR_CONTROL_B: rdata_o <= {4'h0, cfg.wave[2], clock_select};
                tcp_pkg::ADDR_COUNT:     rdata_o <= timer_count;
                tcp_pkg::ADDR_COMPARE_A: rdata_o <= compare_value_a;
                tcp_pkg::ADDR_COMPARE_B: rdata_o <= compare_value_b;
                tcp_pkg::ADDR_FLAGS:     rdata_o <= {5'h00, flags};
                tcp_pkg::ADDR_INT_EN:    rdata_o <= {5'h00, int_en};
                tcp_pkg::ADDR_DIRECTION: rdata_o <= {6'h00, direction};
                default:                 rdata_o <= 8'h00;
            endcase
        end else begin
            rdata_o <= 8'h00;
        end
    end

endmodule

// >>> test/tcp_timer_assertions.sv
/* Port checker for the timer: bus answers, flags and waveform timing.
   Assumes a bind into tcp_timer and the single clock domain on clk_i. */
`timescale 1ns/1ps
module tcp_timer_assertions (
    input wire logic                  clk_i,
    input wire logic                  reset_i,
    input wire tcp_pkg::tcp_bus_req_t bus_i,
    input wire logic [7:0]            rdata_o,
    input wire logic                  service_a_i,
    input wire logic                  service_b_i,
    input wire logic                  service_ovf_i,
    input wire logic [2:0]            irq_o,
    input wire logic                  wave_out_a_o,
    input wire logic                  wave_out_a_oe_o,
    input wire logic                  wave_out_b_o,
    input wire logic                  wave_out_b_oe_o
);
    logic [7:0] sh [9];
    logic [9:0] quiet;
    // Register shadow, written on the same edge the design takes a write
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            for (int i = 0; i < 9; i++) begin
                sh[i] <= 8'h00;
            end
        end else if (bus_i.wr && bus_i.addr < 4'h9) begin
            sh[bus_i.addr] <= bus_i.wdata;
        end
    end
    // Cycles since the last write; running waveforms judged only after a full period, stopped ones after two cycles
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            quiet <= 10'h000;
        end else if (bus_i.wr) begin
            quiet <= 10'h000;
        end else if (quiet != 10'h3FF) begin
            quiet <= quiet + 10'h001;
        end
    end
    // Decoded configuration
    wire [2:0] wm   = {sh[1][3], sh[0][1:0]};
    wire [1:0] ma   = sh[0][7:6];
    wire [1:0] mb   = sh[0][5:4];
    wire       fast = (wm == 3'h3) || (wm == 3'h7);
    wire       stop = (sh[1][2:0] == 3'h0);
    wire       run1 = (sh[1][2:0] == 3'h1) && (quiet > 10'h12C);
    wire       spk  = run1 && wm == 3'h3 && ma == 2'h2 && sh[3] == 8'h00;

    default clocking @(posedge clk_i); endclocking
    default disable iff (reset_i);

    sequence s_cnt_wr_rd;
        bus_i.wr && bus_i.addr == tcp_pkg::ADDR_COUNT ##1 bus_i.rd && bus_i.addr == 4'h2;
    endsequence
    sequence s_spike_gap;
        !wave_out_a_o ##255 wave_out_a_o;
    endsequence

    a_count_write_wins: assert property (s_cnt_wr_rd |=> rdata_o == $past(bus_i.wdata, 2))
        else $error("count read after write differs");
    a_ctla_reserved: assert property (bus_i.rd && bus_i.addr == tcp_pkg::ADDR_CONTROL_A
        |=> rdata_o == (sh[0] & tcp_pkg::CONTROL_A_RD)) else $error("control A read wrong");
    a_stop_holds: assert property (stop && !bus_i.wr && quiet > 10'h001
        |=> $stable({wave_out_a_o, wave_out_b_o})) else $error("waveform moved while stopped");
    a_service_clears: assert property (stop && service_a_i |=> !irq_o[1])
        else $error("service did not clear flag A");
    a_flag_w1c: assert property (stop && bus_i.wr && bus_i.addr == 4'h5 && bus_i.wdata[2]
        |=> !irq_o[2]) else $error("write one did not clear flag B");
    a_irq_masked: assert property ((irq_o & ~sh[6][2:0]) == 3'h0)
        else $error("disabled interrupt requested");
    a_oe_chan_a: assert property (wave_out_a_oe_o ==
        (sh[8][0] && ma != 2'h0 && !(fast && ma == 2'h1 && !wm[2])))
        else $error("pin A driver enable wrong");
    a_oe_chan_b: assert property (wave_out_b_oe_o ==
        (sh[8][1] && mb != 2'h0 && !(fast && mb == 2'h1))) else $error("pin B enable wrong");
    a_toggle_half: assert property (run1 && wm == 3'h7 && ma == 2'h1 && sh[3] == 8'h00
        |=> wave_out_a_o != $past(wave_out_a_o)) else $error("toggle not at half clock");
    a_const_max: assert property (run1 && wm == 3'h3 && ma[1] && sh[3] == 8'hFF
        |-> wave_out_a_o == !ma[0]) else $error("output not constant at max");
    a_spike_period: assert property (spk && $rose(wave_out_a_o) |=> s_spike_gap)
        else $error("spike width or period wrong");
    a_ovf_at_top: assert property (spk && sh[6][0] && $rose(wave_out_a_o) |-> irq_o[0])
        else $error("overflow not set at top");
    a_flag_after_match: assert property (run1 && wm == 3'h0 && mb == 2'h1 && sh[6][2]
        && $changed(wave_out_b_o) |=> irq_o[2]) else $error("flag B late after match");
endmodule

// >>> test/tcp_load.sv
/* Load on one waveform pin: resolves the pin level, counts high cycles.
   Assumes clr_i is a one-cycle pulse from the bench on clk_i. */
`timescale 1ns/1ps
module tcp_load (
    input  wire logic       clk_i,
    input  wire logic       clr_i,
    input  wire logic       out_i,
    input  wire logic       oe_i,
    output logic            pin_o,
    output logic [9:0]      highs_o
);
    logic last = 1'b0;
    // Floating pin shows the inverse of its last level, so no stale value passes
    assign pin_o = oe_i ? out_i : !last;
    // High cycles seen while driven, over the bench window
    always_ff @(posedge clk_i) begin
        last <= pin_o;
        if (clr_i) begin
            highs_o <= 10'h000;
        end else if (oe_i && pin_o) begin
            highs_o <= highs_o + 10'h001;
        end
    end
endmodule

// >>> test/tcp_timer_tb_top.sv
/* Bench top: register, flag, prescale and waveform tests for the timer.
   Assumes checker and load model compiled first; 200 MHz clock. */
`timescale 1ns/1ps
module tcp_timer_tb_top;
    logic                  clk_i = 1'b0;
    logic                  reset_i = 1'b1;
    tcp_pkg::tcp_bus_req_t bus_i = '0;
    logic                  service_a_i = 1'b0;
    logic                  service_b_i = 1'b0;
    logic                  service_ovf_i = 1'b0;
    logic [7:0]            rdata_o;
    logic [2:0]            irq_o;
    logic                  wave_out_a_o, wave_out_a_oe_o, wave_out_b_o, wave_out_b_oe_o;
    logic                  clr = 1'b0;
    logic [9:0]            highs_a;
    logic [9:0]            highs_b;
    logic [7:0]            v, d;
    int                    error_cnt = 0;
    int                    total_checks = 0;
    int                    cyc = 0;
    // {control A, control B, compare A, high cycles or 3FF when off, pin B enabled}
    localparam logic [34:0] CFG [12] = '{{8'h83, 8'h01, 8'h00, 10'h002, 1'b0},
        {8'h83, 8'h01, 8'hFF, 10'h200, 1'b0}, {8'hC3, 8'h01, 8'hFF, 10'h000, 1'b0},
        {8'h43, 8'h09, 8'h00, 10'h100, 1'b0}, {8'h43, 8'h01, 8'h80, 10'h3FF, 1'b0},
        {8'h13, 8'h09, 8'h80, 10'h3FF, 1'b0}, {8'h23, 8'h01, 8'h80, 10'h3FF, 1'b1},
        {8'h40, 8'h01, 8'h80, 10'h100, 1'b0}, {8'h80, 8'h01, 8'h80, 10'h000, 1'b0},
        {8'hC0, 8'h01, 8'h80, 10'h200, 1'b0}, {8'h42, 8'h01, 8'h7F, 10'h100, 1'b0},
        {8'h10, 8'h01, 8'h80, 10'h3FF, 1'b1}};

    tcp_timer u_tcp_timer (.clk_i, .reset_i, .bus_i, .rdata_o, .service_a_i, .service_b_i,
        .service_ovf_i, .irq_o, .wave_out_a_o, .wave_out_a_oe_o, .wave_out_b_o,
        .wave_out_b_oe_o);
    tcp_load u_tcp_load_a (.clk_i, .clr_i(clr), .out_i(wave_out_a_o),
        .oe_i(wave_out_a_oe_o), .pin_o(), .highs_o(highs_a));
    tcp_load u_tcp_load_b (.clk_i, .clr_i(clr), .out_i(wave_out_b_o),
        .oe_i(wave_out_b_oe_o), .pin_o(), .highs_o(highs_b));

    // Clock and hang guard; the ceiling is well above the planned run
    initial forever #2.5 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 50000) begin
            error_cnt++;
            results();
        end
    end

    task automatic results();
        $display("checks %0d mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic chk(string n, logic [9:0] e, logic [9:0] g);
        total_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask
    // Bus tasks start at an edge; a write leaves its strobe for the next task
    task automatic wr(logic [3:0] a, logic [7:0] dt);
        bus_i <= '{a, dt, 1'b1, 1'b0};
        @(posedge clk_i);
    endtask
    task automatic wt(int n);
        bus_i <= '0;
        repeat (n) @(posedge clk_i);
    endtask
    task automatic rd(logic [3:0] a, output logic [7:0] g);
        bus_i <= '{a, 8'h00, 1'b0, 1'b1};
        @(posedge clk_i);
        bus_i <= '0;
        #1 g = rdata_o;
        @(posedge clk_i);
    endtask
    task automatic rdc(logic [3:0] a, logic [7:0] e);
        logic [7:0] g;
        rd(a, g);
        chk("rdata", {2'h0, e}, {2'h0, g});
    endtask
    task automatic ck_irq(logic [2:0] e);
        bus_i <= '0;
        #1 chk("irq", {7'h0, e}, {7'h0, irq_o});
        @(posedge clk_i);
    endtask
    task automatic rst();
        reset_i <= 1'b1;
        bus_i <= '0;
        repeat (3) @(posedge clk_i);
        reset_i <= 1'b0;
        @(posedge clk_i);
    endtask
    // Count expected 3071 cycles after clearing it, for one clock select code
    function automatic logic [7:0] ticks(int c);
        int n;
        n = (c == 1) ? 1 : (c == 2) ? 8 : (c == 3) ? 64 : (c == 4) ? 256 : (c == 5) ? 1024 : 0;
        return (n == 0) ? 8'h00 : 8'(3071 / n);
    endfunction
    // Pin B high cycles over 512 cycles: fast PWM clear mode, else a plain toggle
    function automatic logic [9:0] exp_highs_b(logic [7:0] ctl_a, logic [7:0] cmp_b);
        return (ctl_a[5:4] == 2'h2) ? 10'h002 * ({2'h0, cmp_b} + 10'h001) : 10'h100;
    endfunction

    initial begin
        void'($urandom(70941));
        rst();
        rdc(tcp_pkg::ADDR_CONTROL_A, 8'h00);
        wr(tcp_pkg::ADDR_CONTROL_A, 8'hFF);
        rdc(tcp_pkg::ADDR_CONTROL_A, 8'hF3);
        wr(4'h7, 8'h5A);
        rdc(4'h7, 8'h00);
        wr(tcp_pkg::ADDR_CONTROL_B, 8'h01);
        repeat (4) begin
            v = 8'($urandom);
            wr(tcp_pkg::ADDR_COUNT, v);
            rdc(tcp_pkg::ADDR_COUNT, v);
        end
        $display("test registers done");
        for (int c = 0; c < 8; c++) begin
            rst();
            wr(tcp_pkg::ADDR_CONTROL_B, 8'(c));
            wr(tcp_pkg::ADDR_COUNT, 8'h00);
            wt(3071);
            rd(tcp_pkg::ADDR_COUNT, v);
            d = v - ticks(c);
            chk("count", {2'h0, ticks(c)}, {2'h0, (d <= 8'(c >= 1 && c <= 5)) ? ticks(c) : v});
        end
        $display("test prescale done");
        rst();
        wr(tcp_pkg::ADDR_INT_EN, 8'h07);
        wr(tcp_pkg::ADDR_COMPARE_A, 8'h14);
        wr(tcp_pkg::ADDR_COMPARE_B, 8'h28);
        wr(tcp_pkg::ADDR_CONTROL_B, 8'h01);
        wt(260);
        ck_irq(3'h7);
        wr(tcp_pkg::ADDR_CONTROL_B, 8'h00);
        wr(tcp_pkg::ADDR_INT_EN, 8'h00);
        ck_irq(3'h0);
        wr(tcp_pkg::ADDR_INT_EN, 8'h07);
        bus_i <= '0;
        {service_ovf_i, service_b_i, service_a_i} <= 3'h5;
        @(posedge clk_i);
        {service_ovf_i, service_b_i, service_a_i} <= 3'h0;
        ck_irq(3'h4);
        wr(tcp_pkg::ADDR_FLAGS, 8'h04);
        ck_irq(3'h0);
        $display("test flags done");
        for (int i = 0; i < 12; i++) begin
            rst();
            wr(tcp_pkg::ADDR_DIRECTION, 8'h03);
            wr(tcp_pkg::ADDR_INT_EN, 8'h07);
            wr(tcp_pkg::ADDR_COMPARE_A, CFG[i][18:11]);
            d = 8'($urandom);
            wr(tcp_pkg::ADDR_COMPARE_B, d);
            wr(tcp_pkg::ADDR_CONTROL_A, CFG[i][34:27]);
            wr(tcp_pkg::ADDR_CONTROL_B, CFG[i][26:19]);
            // Service held on so the overflow and B flags stand only in the cycle after their set
            {service_ovf_i, service_b_i} <= 2'h3;
            wt(300);
            clr <= 1'b1;
            wt(1);
            clr <= 1'b0;
            wt(512);
            #1 chk("oe_a", {9'h0, CFG[i][10:1] != 10'h3FF}, {9'h0, wave_out_a_oe_o});
            chk("oe_b", {9'h0, CFG[i][0]}, {9'h0, wave_out_b_oe_o});
            if (CFG[i][10:1] != 10'h3FF) chk("highs_a", CFG[i][10:1], highs_a);
            if (CFG[i][0]) chk("highs_b", exp_highs_b(CFG[i][34:27], d), highs_b);
            {service_ovf_i, service_b_i} <= 2'h0;
        end
        wr(tcp_pkg::ADDR_DIRECTION, 8'h00);
        wt(1);
        #1 chk("oe_dir", 10'h000, {9'h0, wave_out_b_oe_o});
        $display("test waveforms done");
        results();
    end
endmodule

bind tcp_timer tcp_timer_assertions u_tcp_timer_assertions (.clk_i, .reset_i, .bus_i,
    .rdata_o, .service_a_i, .service_b_i, .service_ovf_i, .irq_o, .wave_out_a_o,
    .wave_out_a_oe_o, .wave_out_b_o, .wave_out_b_oe_o);
